// [rtl/cmbm_cfg.svh]
// constants of the message buffer map: offsets, field positions and counts
`ifndef CMBM_CFG_SVH
`define CMBM_CFG_SVH

// region decode
`define CMBM_BASE_ADDR 16'h0100
`define CMBM_REGION_BITS 7
`define CMBM_REGION_BYTES 128

// buffer select digit (address bits 6..4)
`define CMBM_SEL_HIDDEN 3'h2
`define CMBM_SEL_RX 3'h4
`define CMBM_SEL_TX0 3'h5
`define CMBM_SEL_TX1 3'h6
`define CMBM_SEL_TX2 3'h7

// byte offsets inside one 16-byte buffer
`define CMBM_BUF_BYTES 16
`define CMBM_FRAME_BYTES 13
`define CMBM_OFS_ID0 4'h0
`define CMBM_OFS_ID1 4'h1
`define CMBM_OFS_ID2 4'h2
`define CMBM_OFS_ID3 4'h3
`define CMBM_OFS_DATA0 4'h4
`define CMBM_OFS_LEN 4'hc
`define CMBM_OFS_PRIO 4'hd

// bit positions in the identifier bytes
`define CMBM_POS_SRR 4
`define CMBM_POS_IDE 3
`define CMBM_POS_RTR_EXT 0
`define CMBM_POS_RTR_STD 4

// identifier and payload sizes
`define CMBM_STD_ID_BITS 7'd11
`define CMBM_EXT_ID_BITS 7'd29
`define CMBM_MAX_BYTES 4'h8
`define CMBM_SHIFT_BITS 93

`endif

// [rtl/cmbm_pkg.sv]
// types shared by the message buffer map
package cmbm_pkg;

  // one frame as the protocol engine sees it
  typedef struct packed {
    logic [28:0] id;
    logic srr;
    logic ide;
    logic rtr;
    logic [3:0] dlc;
    logic [63:0] data;
  } cmbm_frame_t;

  // header of the frame being sent
  typedef struct packed {
    logic [28:0] id;
    logic srr;
    logic ide;
    logic rtr;
    logic [3:0] dlc;
    logic [3:0] count;
  } cmbm_tx_hdr_t;

  typedef enum logic [0:0] {
    CMBM_TX_IDLE,
    CMBM_TX_SHIFT
  } cmbm_tx_state_t;

endpackage

// [rtl/cmbm_tx_select.sv]
// picks the pending send buffer with the lowest priority byte
`timescale 1ns/100ps
`default_nettype none
module cmbm_tx_select
(
  input wire logic [2:0] i_pending,
  input wire logic [7:0] i_prio0,
  input wire logic [7:0] i_prio1,
  input wire logic [7:0] i_prio2,
  output logic o_any,
  output logic [1:0] o_winner
);

  logic [7:0] best;

  // strict less-than keeps the lower index on a tie
  always_comb
  begin
    o_winner = 2'h0;
    best = 8'hff;
    o_any = |i_pending;
    if (i_pending[0])
    begin
      best = i_prio0;
    end
    if (i_pending[1] && (!i_pending[0] || i_prio1 < best))
    begin
      o_winner = 2'h1;
      best = i_prio1;
    end
    if (i_pending[2] && (i_pending[1:0] == 2'h0 || i_prio2 < best))
    begin
      o_winner = 2'h2;
    end
  end

endmodule
`default_nettype wire

// [rtl/cmbm_top.sv]
// message buffer map: cpu-side buffers, receive store and send serialiser
//
// Overview of operation
// - decode one contiguous 128-byte region of cpu address space
// - hidden receive buffer is readable only in test mode
// - buffers at 0x140 receive, 0x150/0x160/0x170 send zero, one, two
// - each buffer is 16 bytes: 13 frame bytes, priority (send buffers only; receive reads 0), two unused
// - frame bytes have no reset value
// - receive buffer ignores cpu writes; send buffers read and write anytime
// - offsets 0-3 identifier, 4-b payload, c length, d priority, e-f unused
// - identifier bytes hold an 11-bit or 29-bit identifier per buffer
// - extended layout of identifier bytes with substitute remote, format and rtr bits
// - identifier goes out most significant bit first
// - substitute remote bit written as 1 by software; stored as received
// - format flag 0 standard, 1 extended; captured or used to send
// - rtr flag 0 data, 1 remote; captured or used to send
// - length byte carries a 4-bit code, data count 0 to 8
// - remote frame sends length code unchanged and no payload bytes
// - payload goes out from byte 0, most significant bit first
// - lowest priority byte wins; lowest index wins a tie
`timescale 1ns/100ps
`default_nettype none
`include "cmbm_cfg.svh"
module cmbm_top
(
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic [15:0] i_cpu_addr,
  input wire logic [7:0] i_cpu_wdata,
  input wire logic i_cpu_wr,
  input wire logic i_cpu_rd,
  output logic o_cpu_hit,
  output logic [7:0] o_cpu_rdata,
  input wire logic i_test_mode,
  input wire logic i_rx_store,
  input wire cmbm_pkg::cmbm_frame_t i_rx_frame,
  input wire logic i_rx_promote,
  input wire logic [2:0] i_tx_pending,
  input wire logic i_tx_start,
  output logic o_tx_busy,
  output logic [1:0] o_tx_buf,
  output cmbm_pkg::cmbm_tx_hdr_t o_tx_hdr,
  output logic o_tx_bit,
  output logic o_tx_bit_valid,
  input wire logic i_tx_bit_ready,
  output logic o_tx_done
);

  // ==========================================================
  // storage
  // ==========================================================
  // buffers 0..3 are receive, send zero, send one, send two
  logic [7:0] msg_mem [0:63];
  logic [7:0] hidden_mem [0:`CMBM_FRAME_BYTES-1];

  // ==========================================================
  // helper functions
  // ==========================================================
  // payload byte count that actually travels on the bus
  function automatic logic [3:0] byte_count(input logic rtr, input logic [3:0] dlc);
    logic [3:0] n;
    n = dlc;
    if (rtr)
    begin
      n = 4'h0;
    end
    else if (dlc > `CMBM_MAX_BYTES)
    begin
      n = `CMBM_MAX_BYTES;
    end
    return n;
  endfunction

  // one byte of the 13-byte frame image for a received frame
  function automatic logic [7:0] frame_byte(input cmbm_pkg::cmbm_frame_t f,
                                            input logic [3:0] ofs);
    logic [7:0] b;
    b = 8'h00;
    if (f.ide)
    begin
      unique case (ofs)
        `CMBM_OFS_ID0: b = f.id[28:21];
        `CMBM_OFS_ID1: b = {f.id[20:18], f.srr, 1'b1, f.id[17:15]};
        `CMBM_OFS_ID2: b = f.id[14:7];
        `CMBM_OFS_ID3: b = {f.id[6:0], f.rtr};
        default: b = 8'h00;
      endcase
    end
    else
    begin
      unique case (ofs)
        `CMBM_OFS_ID0: b = f.id[10:3];
        `CMBM_OFS_ID1: b = {f.id[2:0], f.rtr, 1'b0, 3'h0};
        default: b = 8'h00;
      endcase
    end
    if (ofs >= `CMBM_OFS_DATA0 && ofs < `CMBM_OFS_LEN)
    begin
      b = f.data[8'd63 - {ofs - `CMBM_OFS_DATA0, 3'h0} -: 8];
    end
    if (ofs == `CMBM_OFS_LEN)
    begin
      b = {4'h0, f.dlc};
    end
    return b;
  endfunction

  // ==========================================================
  // cpu address decode
  // ==========================================================
  logic [2:0] sel_digit;
  logic [3:0] sel_ofs;
  logic [5:0] mem_index;
  logic is_msg;
  logic is_hidden;
  logic in_frame;

  // one 128-byte window above the base
  assign o_cpu_hit = (i_cpu_addr[15:`CMBM_REGION_BITS] ==
                      9'(`CMBM_BASE_ADDR >> `CMBM_REGION_BITS));
  assign sel_digit = i_cpu_addr[6:4];
  assign sel_ofs = i_cpu_addr[3:0];
  assign mem_index = i_cpu_addr[5:0];
  assign is_msg = o_cpu_hit && (sel_digit >= `CMBM_SEL_RX);
  assign is_hidden = o_cpu_hit && (sel_digit == `CMBM_SEL_HIDDEN) && i_test_mode;
  assign in_frame = (sel_ofs < `CMBM_FRAME_BYTES);

  // ==========================================================
  // cpu read path
  // ==========================================================
  logic [7:0] next_rdata;

  always_comb
  begin
    next_rdata = 8'h00;
    if (is_msg)
    begin
      if (in_frame)
      begin
        next_rdata = msg_mem[mem_index];
      end
      else if (sel_ofs == `CMBM_OFS_PRIO && sel_digit != `CMBM_SEL_RX)
      begin
        next_rdata = msg_mem[mem_index];
      end
    end
    else if (is_hidden && in_frame)
    begin
      next_rdata = hidden_mem[sel_ofs];
    end
  end

  // read data lands one clock after the strobe and holds until the next
  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      o_cpu_rdata <= 8'h00;
    end
    else if (i_cpu_rd)
    begin
      o_cpu_rdata <= next_rdata;
    end
  end

  // ==========================================================
  // buffer writes
  // ==========================================================
  logic cpu_tx_write;

  // receive buffer and unused bytes drop cpu writes
  assign cpu_tx_write = i_cpu_wr && is_msg && (sel_digit != `CMBM_SEL_RX) &&
                        (sel_ofs <= `CMBM_OFS_PRIO);

  // no reset on the arrays: contents are undefined until written
  always_ff @(posedge i_ref_clk)
  begin
    if (cpu_tx_write)
    begin
      msg_mem[mem_index] <= i_cpu_wdata;
    end
    if (i_rx_promote)
    begin
      for (int k = 0; k < `CMBM_FRAME_BYTES; k++)
      begin
        msg_mem[k] <= hidden_mem[k];
      end
    end
  end

  // the engine parks a new frame in the hidden buffer
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rx_store)
    begin
      for (int k = 0; k < `CMBM_FRAME_BYTES; k++)
      begin
        hidden_mem[k] <= frame_byte(i_rx_frame, 4'(k));
      end
    end
  end

  // ==========================================================
  // send buffer arbitration
  // ==========================================================
  logic sel_any;
  logic [1:0] sel_win;

  cmbm_tx_select u_select
  (
    .i_pending(i_tx_pending),
    .i_prio0(msg_mem[{2'h1, `CMBM_OFS_PRIO}]),
    .i_prio1(msg_mem[{2'h2, `CMBM_OFS_PRIO}]),
    .i_prio2(msg_mem[{2'h3, `CMBM_OFS_PRIO}]),
    .o_any(sel_any),
    .o_winner(sel_win)
  );

  // ==========================================================
  // frame unpack of the winning buffer
  // ==========================================================
  logic [7:0] w_id0;
  logic [7:0] w_id1;
  logic [7:0] w_id2;
  logic [7:0] w_id3;
  logic [63:0] w_data;
  logic [7:0] w_len;
  cmbm_pkg::cmbm_tx_hdr_t next_hdr;
  logic [`CMBM_SHIFT_BITS-1:0] next_shift;
  logic [6:0] next_bits;

  always_comb
  begin
    w_id0 = msg_mem[{sel_win + 2'h1, `CMBM_OFS_ID0}];
    w_id1 = msg_mem[{sel_win + 2'h1, `CMBM_OFS_ID1}];
    w_id2 = msg_mem[{sel_win + 2'h1, `CMBM_OFS_ID2}];
    w_id3 = msg_mem[{sel_win + 2'h1, `CMBM_OFS_ID3}];
    w_len = msg_mem[{sel_win + 2'h1, `CMBM_OFS_LEN}];
    w_data = 64'h0;
    for (int k = 0; k < 8; k++)
    begin
      w_data[63 - 8 * k -: 8] = msg_mem[{sel_win + 2'h1, 4'(k) + `CMBM_OFS_DATA0}];
    end
    next_hdr.ide = w_id1[`CMBM_POS_IDE];
    next_hdr.dlc = w_len[3:0];
    if (next_hdr.ide)
    begin
      next_hdr.id = {w_id0, w_id1[7:5], w_id1[2:0], w_id2, w_id3[7:1]};
      next_hdr.srr = w_id1[`CMBM_POS_SRR];
      next_hdr.rtr = w_id3[`CMBM_POS_RTR_EXT];
    end
    else
    begin
      next_hdr.id = {18'h0, w_id0, w_id1[7:5]};
      next_hdr.srr = 1'b0;
      next_hdr.rtr = w_id1[`CMBM_POS_RTR_STD];
    end
    next_hdr.count = byte_count(next_hdr.rtr, next_hdr.dlc);
    // identifier then payload, both left-justified for msb-first shifting
    if (next_hdr.ide)
    begin
      next_shift = {next_hdr.id, w_data};
      next_bits = `CMBM_EXT_ID_BITS + {next_hdr.count[3:0], 3'h0};
    end
    else
    begin
      next_shift = {next_hdr.id[10:0], w_data, 18'h0};
      next_bits = `CMBM_STD_ID_BITS + {next_hdr.count[3:0], 3'h0};
    end
  end

  // ==========================================================
  // send serialiser
  // ==========================================================
  cmbm_pkg::cmbm_tx_state_t tx_state;
  logic [`CMBM_SHIFT_BITS-1:0] tx_shift;
  logic [6:0] tx_left;
  logic tx_take;
  logic tx_launch;

  assign tx_take = (tx_state == cmbm_pkg::CMBM_TX_SHIFT) && i_tx_bit_ready;
  assign tx_launch = (tx_state == cmbm_pkg::CMBM_TX_IDLE) && i_tx_start && sel_any;
  assign o_tx_busy = (tx_state == cmbm_pkg::CMBM_TX_SHIFT);
  assign o_tx_bit_valid = o_tx_busy;
  assign o_tx_bit = tx_shift[`CMBM_SHIFT_BITS-1];

  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      tx_state <= cmbm_pkg::CMBM_TX_IDLE;
    end
    else
    begin
      unique case (tx_state)
        cmbm_pkg::CMBM_TX_IDLE:
        begin
          if (tx_launch)
          begin
            tx_state <= cmbm_pkg::CMBM_TX_SHIFT;
          end
        end
        cmbm_pkg::CMBM_TX_SHIFT:
        begin
          if (tx_take && tx_left == 7'd1)
          begin
            tx_state <= cmbm_pkg::CMBM_TX_IDLE;
          end
        end
      endcase
    end
  end

  // the frame is snapshotted at launch so cpu writes cannot tear it
  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      tx_shift <= '0;
      tx_left <= 7'd0;
      o_tx_hdr <= '0;
      o_tx_buf <= 2'h0;
    end
    else if (tx_launch)
    begin
      tx_shift <= next_shift;
      tx_left <= next_bits;
      o_tx_hdr <= next_hdr;
      o_tx_buf <= sel_win;
    end
    else if (tx_take)
    begin
      tx_shift <= {tx_shift[`CMBM_SHIFT_BITS-2:0], 1'b0};
      tx_left <= tx_left - 7'd1;
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      o_tx_done <= 1'b0;
    end
    else
    begin
      o_tx_done <= tx_take && (tx_left == 7'd1);
    end
  end

endmodule
`default_nettype wire

// [tb/cmbm_top_props.sv]
// concurrent checks on the buffer map's cpu and send ports
`timescale 1ns/100ps
`default_nettype none
module cmbm_props
(
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic [15:0] i_cpu_addr,
  input wire logic i_cpu_rd,
  input wire logic o_cpu_hit,
  input wire logic [7:0] o_cpu_rdata,
  input wire logic i_test_mode,
  input wire logic [2:0] i_tx_pending,
  input wire logic i_tx_start,
  input wire logic o_tx_busy,
  input wire logic [1:0] o_tx_buf,
  input wire cmbm_pkg::cmbm_tx_hdr_t o_tx_hdr,
  input wire logic o_tx_bit,
  input wire logic o_tx_bit_valid,
  input wire logic i_tx_bit_ready,
  input wire logic o_tx_done
);
  // ==========
  // properties
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_srst);
  sequence s_read(c);
    i_cpu_rd && c;
  endsequence
  sequence s_launch;
    i_tx_start && !o_tx_busy && (|i_tx_pending);
  endsequence
  sequence s_pulse;
    o_tx_done ##1 !o_tx_done;
  endsequence
  a_region_decode: assert property (
    o_cpu_hit == (i_cpu_addr[15:7] == 9'h002))
    else $error("region decode wrong");
  a_miss_reads_zero: assert property (
    s_read(!o_cpu_hit) |=> o_cpu_rdata == 8'h00)
    else $error("out of region read not zero");
  a_hidden_masked: assert property (
    s_read(!i_test_mode && i_cpu_addr[15:4] == 12'h012) |=> o_cpu_rdata == 8'h00)
    else $error("hidden buffer visible");
  a_spare_zero: assert property (
    s_read(i_cpu_addr[15:6] == 10'h005 && i_cpu_addr[3:1] == 3'h7)
    |=> o_cpu_rdata == 8'h00)
    else $error("unused byte not zero");
  a_rx_prio_zero: assert property (
    s_read(i_cpu_addr == 16'h014d) |=> o_cpu_rdata == 8'h00)
    else $error("receive priority byte not zero");
  a_launch_valid: assert property (
    s_launch |=> o_tx_busy && o_tx_bit_valid && o_tx_buf != 2'h3)
    else $error("launch missing");
  a_busy_refused: assert property (
    i_tx_start && o_tx_busy |=> $stable(o_tx_buf) && $stable(o_tx_hdr))
    else $error("start taken while busy");
  a_remote_count: assert property (
    $rose(o_tx_busy) && o_tx_hdr.rtr |-> o_tx_hdr.count == 4'h0)
    else $error("remote frame carries data");
  a_data_count: assert property (
    $rose(o_tx_busy) && !o_tx_hdr.rtr
    |-> o_tx_hdr.count == (o_tx_hdr.dlc > 4'h8 ? 4'h8 : o_tx_hdr.dlc))
    else $error("data count wrong");
  a_bit_holds: assert property (
    o_tx_bit_valid && !i_tx_bit_ready |=> o_tx_bit_valid && $stable(o_tx_bit))
    else $error("bit changed before taken");
  a_done_pulse: assert property (
    $fell(o_tx_busy) |-> ##[0:1] s_pulse)
    else $error("done pulse wrong");
endmodule
bind cmbm_top cmbm_props i_props (.i_ref_clk, .i_srst, .i_cpu_addr, .i_cpu_rd, .o_cpu_hit,
  .o_cpu_rdata, .i_test_mode, .i_tx_pending, .i_tx_start, .o_tx_busy, .o_tx_buf, .o_tx_hdr,
  .o_tx_bit, .o_tx_bit_valid, .i_tx_bit_ready, .o_tx_done);
`default_nettype wire

// [tb/cmbm_sink_model.sv]
// engine stand-in: takes send bits, stalling one cycle in four
`timescale 1ns/100ps
`default_nettype none
module cmbm_sink_model
(
  input wire logic i_ref_clk,
  input wire logic i_clr,
  input wire logic i_valid,
  input wire logic i_bit,
  output logic o_ready,
  output logic [127:0] o_bits,
  output logic [7:0] o_n
);
  // ==========
  // bit capture
  logic [1:0] phase;
  assign o_ready = (phase != 2'h3);
  always_ff @(posedge i_ref_clk)
  begin
    if (i_clr)
    begin
      phase <= 2'h0;
      o_n <= 8'h00;
      o_bits <= '0;
    end
    else
    begin
      phase <= phase + 2'h1;
      if (i_valid && o_ready)
      begin
        o_bits <= {o_bits[126:0], i_bit};
        o_n <= o_n + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// [tb/can_message_buffer_map_tb.sv]
// self-checking bench of the buffer map
`timescale 1ns/100ps
`default_nettype none
module can_message_buffer_map_tb;
  // ==========
  // bench
  logic clk, srst, wr, rd, tm, rx_st, rx_pr, start, clr, hit, busy, tbit, valid, ready, done;
  logic [15:0] addr;
  logic [7:0] wd, rdq, n;
  logic [2:0] pend;
  logic [1:0] tbuf;
  logic [127:0] bits;
  logic [103:0] rxe;
  cmbm_pkg::cmbm_frame_t frm;
  cmbm_pkg::cmbm_tx_hdr_t hdr;
  int err_total, checks_done, cyc, k;
  cmbm_top i_dut (.i_ref_clk(clk), .i_srst(srst), .i_cpu_addr(addr), .i_cpu_wdata(wd),
    .i_cpu_wr(wr), .i_cpu_rd(rd), .o_cpu_hit(hit), .o_cpu_rdata(rdq), .i_test_mode(tm),
    .i_rx_store(rx_st), .i_rx_frame(frm), .i_rx_promote(rx_pr), .i_tx_pending(pend),
    .i_tx_start(start), .o_tx_busy(busy), .o_tx_buf(tbuf), .o_tx_hdr(hdr), .o_tx_bit(tbit),
    .o_tx_bit_valid(valid), .i_tx_bit_ready(ready), .o_tx_done(done));
  cmbm_sink_model i_sink (.i_ref_clk(clk), .i_clr(clr), .i_valid(valid), .i_bit(tbit),
    .o_ready(ready), .o_bits(bits), .o_n(n));
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic finish_test();
    $display("errors %0d checks %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [127:0] e, input logic [127:0] g);
    checks_done++;
    if (g !== e)
    begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  function automatic logic [31:0] idb(input logic [28:0] id, input logic s, input logic x,
    input logic r);
    if (x)
      return {id[28:18], s, 1'b1, id[17:0], r};
    return {id[10:3], id[2:0], r, 1'b0, 19'h0};
  endfunction
  task automatic wr8(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wd = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask
  task automatic rd8(input logic [15:0] a, input logic [7:0] e);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    chk($sformatf("byte %h", a), e, rdq);
  endtask
  task automatic wbuf(input logic [15:0] b, input logic [103:0] v, input logic [7:0] p);
    for (int i = 0; i < 13; i++)
      wr8(b + 16'(i), v[103 - 8 * i -: 8]);
    wr8(b + 16'hd, p);
  endtask
  task automatic rbuf(input logic [15:0] b, input logic [103:0] v);
    for (int i = 0; i < 13; i++)
      rd8(b + 16'(i), v[103 - 8 * i -: 8]);
  endtask
  task automatic send(input logic [2:0] p, input logic [1:0] b, input logic [3:0] c,
    input logic [127:0] e, input logic [7:0] nb);
    pend = p;
    clr = 1'b1;
    @(negedge clk);
    clr = 1'b0;
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    chk("winner", b, tbuf);
    chk("count", c, hdr.count);
    @(negedge clk);
    // a start while busy must be ignored
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    for (k = 0; k < 400 && done !== 1'b1; k++)
      @(negedge clk);
    chk("done", 1'b1, done);
    chk("bits", e, bits);
    chk("bit count", nb, n);
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      finish_test();
    end
  end
  initial
  begin
    {srst, wr, rd, tm, rx_st, rx_pr, start, clr} = 8'hff & 8'h81;
    addr = 16'h0000;
    wd = 8'h00;
    pend = 3'h0;
    frm = {29'h1555aaa5, 1'b0, 1'b1, 1'b0, 4'h4, 64'hdeadbeef01020304};
    rxe = {idb(29'h1555aaa5, 1'b0, 1'b1, 1'b0), 64'hdeadbeef01020304, 8'h04};
    repeat (8) @(negedge clk);
    srst = 1'b0;
    rx_st = 1'b1;
    @(negedge clk);
    rx_st = 1'b0;
    rd8(16'h0121, 8'h00);
    tm = 1'b1;
    rbuf(16'h0120, rxe);
    rx_pr = 1'b1;
    @(negedge clk);
    rx_pr = 1'b0;
    rbuf(16'h0140, rxe);
    wr8(16'h0143, 8'hff);
    rd8(16'h0143, rxe[79:72]);
    rd8(16'h014d, 8'h00);
    chk("hit", 1'b1, hit);
    rd8(16'h0180, 8'h00);
    chk("hit", 1'b0, hit);
    wr8(16'h015e, 8'h5a);
    rd8(16'h015e, 8'h00);
    wbuf(16'h0150, {idb(29'h0abcdef1, 1'b1, 1'b1, 1'b1), 64'h0, 8'h03}, 8'h05);
    wbuf(16'h0160, {idb(29'h5a3, 1'b0, 1'b0, 1'b0), 64'h1122334455667788, 8'h09},
      8'h03);
    wbuf(16'h0170, {idb(29'h0abcdef1, 1'b1, 1'b1, 1'b1), 64'h0, 8'h03}, 8'h03);
    rbuf(16'h0160, {idb(29'h5a3, 1'b0, 1'b0, 1'b0), 64'h1122334455667788, 8'h09});
    send(3'h7, 2'h1, 4'h8, {53'h0, 11'h5a3, 64'h1122334455667788}, 8'd75);
    chk("header", {18'h0, 11'h5a3, 3'h0, 4'h9, 4'h8}, hdr);
    send(3'h5, 2'h2, 4'h0, {99'h0, 29'h0abcdef1}, 8'd29);
    chk("header", {29'h0abcdef1, 3'h7, 4'h3, 4'h0}, hdr);
    finish_test();
  end
endmodule
`default_nettype wire
